// file: design/udp_stream_host.sv
`timescale 1ns/100ps
`include "udp_host_consts.svh"

// Notes on behaviour
// - each accept strobe carries one 64-bit word the device stores
// - frame-last rises only together with the accept of the final word
// - target address and port are valid in the frame-last cycle
// - frames never exceed 1088 words (8704 bytes)
// - no new word is pushed in the cycle after nearly-full is seen high
// - each presented receive word is acknowledged, then the next appears
// - overrun comes with frame-last; device stalls until acknowledged
// - overrun acknowledge is tied straight to the overrun input
// - target address is one 32-bit value, first octet on top
// - target ports are chosen from 49152 to 65535
module udp_stream_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output udp_host_pkg::send_bus_t send_out,
    output logic dev_reset,
    input wire udp_host_pkg::recv_bus_t recv_in,
    output logic recv_ack,
    output logic recv_overrun_ack,
    input wire udp_host_pkg::dev_status_t dev_status
);

    udp_host_pkg::host_state_t s_ff;
    udp_host_pkg::host_state_t nxt_s;
    logic wr_en;
    logic rd_setup;
    logic [8:0] status_word;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    // zero wait states: read data is latched in the setup cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign prdata = s_ff.prdata;
    assign pslverr = s_ff.pslverr;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `OFS_CTRL) || (a == `OFS_LEN) || (a == `OFS_SEED)
            || (a == `OFS_DEST_ADDR) || (a == `OFS_DEST_PORT)
            || (a == `OFS_STATUS) || (a == `OFS_RX_LO)
            || (a == `OFS_RX_HI) || (a == `OFS_RX_SENDER)
            || (a == `OFS_RX_PORT) || (a == `OFS_FRAMES);
    endfunction

    // live and sticky status
    always_comb begin
        status_word = '0;
        status_word[`ST_BUSY] = (s_ff.st == udp_host_pkg::ST_SEND);
        status_word[`ST_AFULL] = dev_status.nearly_full;
        status_word[`ST_OVERFLOW] = dev_status.overflowed;
        status_word[`ST_LINK] = dev_status.link_up;
        status_word[`ST_BAD] = s_ff.bad_seen;
        status_word[`ST_OVERRUN] = s_ff.ovr_seen;
        status_word[`ST_PORT_REJ] = s_ff.port_rej;
        status_word[`ST_RX_ACT] = dev_status.rx_activity;
        status_word[`ST_TX_ACT] = dev_status.tx_activity;
    end

    ////////////////////////////////////////////////////////////////////
    // receive side: always ready, so ack follows valid

    assign recv_ack = recv_in.valid;
    // straight tie lets the device recover on its own
    assign recv_overrun_ack = recv_in.overrun;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_s = s_ff;
        nxt_s.snd.accept = 1'b0;
        nxt_s.snd.last = 1'b0;
        nxt_s.dev_reset = 1'b0;
        nxt_s.pslverr = 1'b0;

        // register writes
        if (wr_en) begin
            case (paddr)
                `OFS_CTRL: begin
                    if (pwdata[`CTRL_START] && s_ff.len != 11'h000
                        && s_ff.st == udp_host_pkg::ST_IDLE) begin
                        nxt_s.st = udp_host_pkg::ST_SEND;
                        nxt_s.idx = '0;
                    end
                    // only way out of a device overflow
                    if (pwdata[`CTRL_DEV_RESET]) begin
                        nxt_s.dev_reset = 1'b1;
                        nxt_s.st = udp_host_pkg::ST_IDLE;
                    end
                end
                `OFS_LEN: begin
                    // longer frames are clipped, never sent as asked
                    if (pwdata[10:0] > `TX_MAX_WORDS || pwdata[31:11] != '0)
                        nxt_s.len = `TX_MAX_WORDS;
                    else
                        nxt_s.len = pwdata[10:0];
                end
                `OFS_SEED: nxt_s.seed = pwdata;
                // first octet sits in the top byte
                `OFS_DEST_ADDR: nxt_s.dest_addr = pwdata;
                `OFS_DEST_PORT: begin
                    if (pwdata[15:0] >= `PORT_MIN) begin
                        nxt_s.dest_port = pwdata[15:0];
                        nxt_s.port_rej = 1'b0;
                    end else begin
                        nxt_s.port_rej = 1'b1;
                    end
                end
                `OFS_STATUS: begin
                    if (pwdata[`ST_BAD])
                        nxt_s.bad_seen = 1'b0;
                    if (pwdata[`ST_OVERRUN])
                        nxt_s.ovr_seen = 1'b0;
                    if (pwdata[`ST_PORT_REJ])
                        nxt_s.port_rej = 1'b0;
                end
                default: nxt_s.pslverr = ~mapped(paddr);
            endcase
        end else if (psel & ~penable) begin
            nxt_s.pslverr = ~mapped(paddr);
        end

        // read data latched in the setup cycle
        if (rd_setup) begin
            case (paddr)
                `OFS_CTRL: nxt_s.prdata = {31'h0, status_word[`ST_BUSY]};
                `OFS_LEN: nxt_s.prdata = {21'h0, s_ff.len};
                `OFS_SEED: nxt_s.prdata = s_ff.seed;
                `OFS_DEST_ADDR: nxt_s.prdata = s_ff.dest_addr;
                `OFS_DEST_PORT: nxt_s.prdata = {16'h0, s_ff.dest_port};
                `OFS_STATUS: nxt_s.prdata = {23'h0, status_word};
                `OFS_RX_LO: nxt_s.prdata = s_ff.rx_word[31:0];
                `OFS_RX_HI: nxt_s.prdata = s_ff.rx_word[63:32];
                `OFS_RX_SENDER: nxt_s.prdata = s_ff.rx_sender;
                `OFS_RX_PORT: nxt_s.prdata = {16'h0, s_ff.rx_port};
                `OFS_FRAMES: nxt_s.prdata = {s_ff.rx_frames, s_ff.tx_frames};
                default: nxt_s.prdata = 32'h0000_0000;
            endcase
        end

        // frame sender; a word is pushed only when the device has room
        case (s_ff.st)
            udp_host_pkg::ST_IDLE: begin
            end
            udp_host_pkg::ST_SEND: begin
                // afull is late by one cycle, the margin absorbs that
                if (!dev_status.nearly_full && !dev_status.overflowed
                    && !nxt_s.dev_reset) begin
                    nxt_s.snd.accept = 1'b1;
                    nxt_s.snd.word = {s_ff.seed, 21'h0, s_ff.idx};
                    if (s_ff.idx == s_ff.len - 11'h001) begin
                        nxt_s.snd.last = 1'b1;
                        // address loaded with the last word only, then kept until the next
                        nxt_s.snd.target_address = s_ff.dest_addr;
                        nxt_s.snd.target_port = s_ff.dest_port;
                        nxt_s.st = udp_host_pkg::ST_IDLE;
                        nxt_s.tx_frames = s_ff.tx_frames + 16'h0001;
                    end else begin
                        nxt_s.idx = s_ff.idx + 11'h001;
                    end
                end
            end
            default: nxt_s.st = udp_host_pkg::ST_IDLE;
        endcase

        // capture each acknowledged receive word
        if (recv_in.valid) begin
            nxt_s.rx_word = recv_in.word;
            nxt_s.rx_sender = recv_in.sender_address;
            nxt_s.rx_port = recv_in.sender_port;
            if (recv_in.last) begin
                nxt_s.rx_frames = s_ff.rx_frames + 16'h0001;
                // set wins over a clear in the same cycle
                if (recv_in.bad_frame)
                    nxt_s.bad_seen = 1'b1;
                if (recv_in.overrun)
                    nxt_s.ovr_seen = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.st <= udp_host_pkg::ST_IDLE;
            s_ff.len <= `RST_LEN;
            s_ff.seed <= `RST_SEED;
            s_ff.dest_addr <= `RST_DEST_ADDR;
            s_ff.dest_port <= `RST_DEST_PORT;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign send_out = s_ff.snd;
    assign dev_reset = s_ff.dev_reset;

    ////////////////////////////////////////////////////////////////////
    // checks

    // words in the frame now being pushed
    logic [10:0] frame_cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            frame_cnt_ff <= '0;
        // a device reset drops the part frame, so the count restarts
        else if (dev_reset)
            frame_cnt_ff <= '0;
        else if (send_out.accept)
            frame_cnt_ff <= send_out.last ? 11'h000 : frame_cnt_ff + 11'h001;
    end

    property p_last_with_accept;
        @(posedge pclk) disable iff (!presetn)
        send_out.last |-> send_out.accept;
    endproperty
    a_last_with_accept: assert property (p_last_with_accept)
        else $error("frame-last without accept");

    property p_last_pulse;
        @(posedge pclk) disable iff (!presetn)
        send_out.last |=> !send_out.last;
    endproperty
    a_last_pulse: assert property (p_last_pulse)
        else $error("frame-last held two cycles");

    property p_stop_on_afull;
        @(posedge pclk) disable iff (!presetn)
        dev_status.nearly_full |=> !send_out.accept;
    endproperty
    a_stop_on_afull: assert property (p_stop_on_afull)
        else $error("word pushed after nearly-full");

    property p_frame_len;
        @(posedge pclk) disable iff (!presetn)
        send_out.accept |-> frame_cnt_ff < `TX_MAX_WORDS;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame longer than buffer");

    property p_ack_valid;
        @(posedge pclk) disable iff (!presetn)
        recv_ack == recv_in.valid;
    endproperty
    a_ack_valid: assert property (p_ack_valid)
        else $error("receive ack mismatched to valid");

    property p_rx_capture;
        @(posedge pclk) disable iff (!presetn)
        recv_in.valid |=> s_ff.rx_word == $past(recv_in.word);
    endproperty
    a_rx_capture: assert property (p_rx_capture)
        else $error("acknowledged word not captured");

    property p_overrun_seen;
        @(posedge pclk) disable iff (!presetn)
        recv_in.valid && recv_in.last && recv_in.overrun |=> s_ff.ovr_seen;
    endproperty
    a_overrun_seen: assert property (p_overrun_seen)
        else $error("overrun not recorded");

    property p_port_range;
        @(posedge pclk) disable iff (!presetn)
        send_out.last |-> send_out.target_port >= `PORT_MIN;
    endproperty
    a_port_range: assert property (p_port_range)
        else $error("target port below dynamic range");

    property p_last_target;
        @(posedge pclk) disable iff (!presetn)
        send_out.last |-> send_out.target_address == $past(s_ff.dest_addr)
            && send_out.target_port == $past(s_ff.dest_port);
    endproperty
    a_last_target: assert property (p_last_target)
        else $error("target not taken from the set address and port");

    // a blocked device takes nothing until it has been reset
    property p_hold_on_ovf;
        @(posedge pclk) disable iff (!presetn)
        dev_status.overflowed |=> !send_out.accept;
    endproperty
    a_hold_on_ovf: assert property (p_hold_on_ovf)
        else $error("word pushed while device overflowed");

endmodule

// file: pkg/udp_host_consts.svh
`ifndef UDP_HOST_CONSTS_SVH
`define UDP_HOST_CONSTS_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_LEN 8'h04
`define OFS_SEED 8'h08
`define OFS_DEST_ADDR 8'h0C
`define OFS_DEST_PORT 8'h10
`define OFS_STATUS 8'h14
`define OFS_RX_LO 8'h18
`define OFS_RX_HI 8'h1C
`define OFS_RX_SENDER 8'h20
`define OFS_RX_PORT 8'h24
`define OFS_FRAMES 8'h28

// control bits
`define CTRL_START 0
`define CTRL_DEV_RESET 1

// status bits
`define ST_BUSY 0
`define ST_AFULL 1
`define ST_OVERFLOW 2
`define ST_LINK 3
`define ST_BAD 4
`define ST_OVERRUN 5
`define ST_PORT_REJ 6
`define ST_RX_ACT 7
`define ST_TX_ACT 8

// frame limits and defaults
`define TX_MAX_WORDS 11'h440
`define PORT_MIN 16'hC000
`define RST_LEN 11'h001
`define RST_SEED 32'h0000_0000
`define RST_DEST_ADDR 32'hC0A8_0101
`define RST_DEST_PORT 16'hC000

`endif

// file: pkg/udp_host_pkg.sv
package udp_host_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } tx_state_t;

    // words pushed toward the transceiver
    typedef struct packed {
        logic [63:0] word;
        logic accept;
        logic last;
        logic [31:0] target_address;
        logic [15:0] target_port;
    } send_bus_t;

    // words coming back from the transceiver
    typedef struct packed {
        logic valid;
        logic [63:0] word;
        logic last;
        logic bad_frame;
        logic overrun;
        logic [31:0] sender_address;
        logic [15:0] sender_port;
    } recv_bus_t;

    // device status levels
    typedef struct packed {
        logic nearly_full;
        logic overflowed;
        logic link_up;
        logic rx_activity;
        logic tx_activity;
    } dev_status_t;

    typedef struct packed {
        tx_state_t st;
        logic [10:0] len;
        logic [10:0] idx;
        logic [31:0] seed;
        logic [31:0] dest_addr;
        logic [15:0] dest_port;
        send_bus_t snd;
        logic dev_reset;
        logic [63:0] rx_word;
        logic [31:0] rx_sender;
        logic [15:0] rx_port;
        logic [15:0] rx_frames;
        logic [15:0] tx_frames;
        logic bad_seen;
        logic ovr_seen;
        logic port_rej;
        logic [31:0] prdata;
        logic pslverr;
    } host_state_t;

endpackage

// file: verif/udp_dev_model.sv
`timescale 1ns/100ps
// behavioural transceiver standing in for the device beside the host
module udp_dev_model #(
    parameter int AFULL = 1080,
    parameter int DEPTH = 1088
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire udp_host_pkg::send_bus_t snd,
    input wire logic dev_reset,
    output udp_host_pkg::recv_bus_t rcv,
    input wire logic recv_ack,
    input wire logic recv_overrun_ack,
    output udp_host_pkg::dev_status_t st,
    input wire logic slow,
    input wire logic force_ovf,
    input wire logic rx_go,
    input wire logic [3:0] rx_len,
    input wire logic [1:0] rx_flags,
    input wire logic [63:0] rx_base
);
    typedef struct packed {
        logic [10:0] fill;
        logic [10:0] sealed;
        logic [2:0] tick;
        logic [3:0] left;
        logic [1:0] flags;
        logic ovf;
        logic stall;
        logic [63:0] word;
    } model_t;
    model_t s_ff, nxt_s;
    logic inc, dec, take;
    ////////////////////////////////////////////////////////////////////////
    // a frame drains only once its last word seals it
    assign inc = snd.accept && !s_ff.ovf && s_ff.fill < DEPTH;
    assign dec = s_ff.sealed != 11'h0 && s_ff.tick == 3'h0;
    assign take = recv_ack && s_ff.left != 4'h0;
    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = s_ff.tick == 3'h0 ? {3{slow}} : s_ff.tick - 3'h1;
        nxt_s.fill = s_ff.fill + {10'h0, inc} - {10'h0, dec};
        nxt_s.sealed = s_ff.sealed - {10'h0, dec};
        if (snd.last && inc) nxt_s.sealed = nxt_s.fill;
        if (force_ovf || (snd.accept && s_ff.fill >= DEPTH)) begin
            nxt_s.ovf = 1'b1;
        end
        if (take) begin
            nxt_s.left = s_ff.left - 4'h1;
            nxt_s.word = s_ff.word + 64'h1;
        end else if (s_ff.left == 4'h0) begin
            nxt_s.word = ~s_ff.word; // idle data must not look held
        end
        if (take && rcv.last && s_ff.flags[1])
            nxt_s.stall = 1'b1;
        if (recv_overrun_ack) nxt_s.stall = 1'b0;
        if (rx_go && s_ff.left == 4'h0 && !s_ff.stall) begin
            nxt_s.left = rx_len;
            nxt_s.flags = rx_flags;
            nxt_s.word = rx_base;
        end
        if (dev_reset) nxt_s = '0;
    end
    // state register; comes up enabled with no software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
    // receive side and status levels straight from the state
    always_comb begin
        rcv.valid = s_ff.left != 4'h0;
        rcv.word = s_ff.word;
        rcv.last = s_ff.left == 4'h1;
        rcv.bad_frame = s_ff.left == 4'h1 && s_ff.flags[0];
        rcv.overrun = s_ff.left == 4'h1 && s_ff.flags[1];
        rcv.sender_address = 32'h0A00_0002;
        rcv.sender_port = 16'hC001;
    end
    // one process per struct output keeps a single driver on each
    always_comb begin
        st.nearly_full = s_ff.fill >= AFULL;
        st.overflowed = s_ff.ovf;
        st.link_up = 1'b1;
        st.rx_activity = s_ff.left != 4'h0;
        st.tx_activity = s_ff.sealed != 11'h0;
    end
endmodule

// file: verif/tb_udp_stream_host.sv
`timescale 1ns/100ps
`include "udp_host_consts.svh"
module tb_udp_stream_host;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic e;
    } note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic dev_reset, ack, oack, slow, fovf, go, prev_nf = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, addr;
    logic [15:0] port;
    logic [3:0] rlen;
    logic [1:0] flg;
    logic [63:0] base;
    udp_host_pkg::send_bus_t snd, tx_q[$];
    udp_host_pkg::recv_bus_t rcv;
    udp_host_pkg::dev_status_t st;
    note_t rd_q[$];
    int err_total, total_checks, n;
    logic [7:0] ra[5] = '{`OFS_LEN, `OFS_SEED, `OFS_DEST_ADDR,
        `OFS_DEST_PORT, `OFS_FRAMES};
    logic [31:0] rv[5] = '{32'h1, 32'h0, 32'hC0A8_0101, 32'hC000, 32'h0};
    udp_stream_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .send_out(snd), .dev_reset(dev_reset),
        .recv_in(rcv), .recv_ack(ack), .recv_overrun_ack(oack),
        .dev_status(st));
    udp_dev_model #(.AFULL(6), .DEPTH(1088)) dev (.pclk(pclk),
        .presetn(presetn), .snd(snd), .dev_reset(dev_reset), .rcv(rcv),
        .recv_ack(ack), .recv_overrun_ack(oack), .st(st), .slow(slow),
        .force_ovf(fovf), .rx_go(go), .rx_len(rlen), .rx_flags(flg),
        .rx_base(base));
    ////////////////////////////////////////////////////////////////////////
    // free-running clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tally(input logic ok, input string s);
        total_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask
    task automatic timeout;
        tally(1'b0, "wait ran out");
        finish_test;
    endtask
    task automatic cmp_rd(input note_t e);
        tally((prdata & e.m) === (e.d & e.m) && pslverr === e.e, "read");
    endtask
    // targets only matter on the last word
    task automatic cmp_tx(input udp_host_pkg::send_bus_t g, e);
        if (!e.last) g[47:0] = e[47:0];
        tally(g === e, "send word");
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] d, m,
                       input logic e);
        rd_q.push_back('{d, m, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic idle;
        for (int i = 0; i < 300; i++) begin
            rdc(`OFS_STATUS, 32'h8, 32'hC, 1'b0);
            if (rd[0] === 1'b0) return;
        end
        timeout;
    endtask
    task automatic send(input int len);
        for (int i = 0; i < len; i++) begin
            tx_q.push_back({seed, 21'h0, i[10:0], 1'b1, i == len - 1,
                addr, port});
        end
        apb(1'b1, `OFS_LEN, len);
        apb(1'b1, `OFS_CTRL, 32'h1);
        idle;
    endtask
    // one received frame, then its last word and sender read back
    task automatic rx(input logic [3:0] l, input logic [1:0] f);
        logic [63:0] w;
        @(posedge pclk);
        rlen <= l;
        flg <= f;
        base <= {$urandom, $urandom};
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        for (n = 0; rcv.valid !== 1'b0 && n < 40; n++) @(posedge pclk);
        if (n >= 40) timeout;
        w = base + {60'h0, l} - 64'h1;
        rdc(`OFS_RX_LO, w[31:0], 32'hFFFF_FFFF, 1'b0);
        rdc(`OFS_RX_HI, w[63:32], 32'hFFFF_FFFF, 1'b0);
        rdc(`OFS_RX_SENDER, 32'h0A00_0002, 32'hFFFF_FFFF, 1'b0);
        rdc(`OFS_RX_PORT, 32'hC001, 32'hFFFF, 1'b0);
    endtask
    // watch reads and send words against the oldest notes
    always @(posedge pclk) begin
        prev_nf <= st.nearly_full;
        if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
            cmp_rd(rd_q.pop_front());
        end
        if (snd.accept === 1'b1) begin
            tally(!prev_nf, "word after nearly full");
            if (tx_q.size() == 0) tally(1'b0, "stray word");
            else cmp_tx(snd, tx_q.pop_front());
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {slow, fovf, go, flg, rlen, base} = '0;
        presetn = 1'b0;
        void'($urandom(32'h984D));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`OFS_STATUS, 32'h8, 32'h7F, 1'b0);
        foreach (ra[i]) rdc(ra[i], rv[i], 32'hFFFF_FFFF, 1'b0);
        rdc(8'h40, 32'h0, 32'hFFFF_FFFF, 1'b1);
        // ports below the dynamic range are refused and flagged
        apb(1'b1, `OFS_DEST_PORT, 32'h1234);
        rdc(`OFS_DEST_PORT, 32'hC000, 32'hFFFF, 1'b0);
        rdc(`OFS_STATUS, 32'h40, 32'h40, 1'b0);
        apb(1'b1, `OFS_STATUS, 32'h40);
        rdc(`OFS_STATUS, 32'h0, 32'h40, 1'b0);
        seed = $urandom;
        addr = $urandom;
        port = 16'hC000 | 16'($urandom);
        apb(1'b1, `OFS_SEED, seed);
        apb(1'b1, `OFS_DEST_ADDR, addr);
        apb(1'b1, `OFS_DEST_PORT, {16'h0, port});
        send(1);
        send(3);
        apb(1'b1, `OFS_LEN, 32'h44C);
        rdc(`OFS_LEN, 32'h440, 32'hFFFF_FFFF, 1'b0);
        // slow drain keeps the first frame queued, so the second stalls
        slow <= 1'b1;
        send(5);
        send(5);
        slow <= 1'b0;
        rdc(`OFS_FRAMES, 32'h4, 32'hFFFF, 1'b0);
        rx(4'h3, 2'b01);
        rdc(`OFS_STATUS, 32'h10, 32'h10, 1'b0);
        rx(4'h2, 2'b10);
        rx(4'h1, 2'b00);
        rdc(`OFS_STATUS, 32'h20, 32'h20, 1'b0);
        rdc(`OFS_FRAMES, 32'h0003_0004, 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, `OFS_STATUS, 32'h30);
        rdc(`OFS_STATUS, 32'h0, 32'h30, 1'b0);
        // forced overflow holds the sender until the device reset
        fovf <= 1'b1;
        @(posedge pclk);
        fovf <= 1'b0;
        apb(1'b1, `OFS_LEN, 32'h2);
        apb(1'b1, `OFS_CTRL, 32'h1);
        rdc(`OFS_STATUS, 32'h5, 32'h5, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h2);
        rdc(`OFS_STATUS, 32'h0, 32'h5, 1'b0);
        finish_test;
    end
endmodule
